// file: logic/qpsram_pkg.sv
package qpsram_pkg;

  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NPORTS = 4;
  localparam int unsigned CLK_NS = 20;

  // fastest-grade figures, in ns
  localparam int unsigned T_WP_NS = 15;
  localparam int unsigned T_DW_NS = 15;
  localparam int unsigned T_AW_NS = 15;
  localparam int unsigned T_WZ_NS = 12;
  localparam int unsigned T_AA_NS = 20;
  localparam int unsigned T_HZ_NS = 12;
  localparam int unsigned T_WH_NS = 15;
  localparam int unsigned T_WDD_NS = 35;

  // least times round up, never below one cycle
  localparam int unsigned WP_CYC_I = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WZDW_CYC_I =
    (T_WZ_NS + T_DW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RD_CYC_I = (T_AA_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int unsigned HZ_CYC_I = (T_HZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WH_CYC_I = (T_WH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned XP_CYC_I = (T_WDD_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [3:0] WP_CYC = WP_CYC_I[3:0];
  localparam logic [3:0] WPOE_CYC =
    (WZDW_CYC_I > WP_CYC_I) ? WZDW_CYC_I[3:0] : WP_CYC_I[3:0];
  localparam logic [3:0] RD_CYC = RD_CYC_I[3:0];
  localparam logic [3:0] HZ_CYC = HZ_CYC_I[3:0];
  localparam logic [3:0] WH_CYC = WH_CYC_I[3:0];
  localparam logic [3:0] XP_CYC = XP_CYC_I[3:0];
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  typedef struct packed {
    logic we;
    logic oe_during_write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } qpsram_req_t;

  // pins of one port, as driven by the host
  typedef struct packed {
    logic ce_n;
    logic rw;
    logic oe_n;
    logic inhibit_n;
    logic [ADDR_W-1:0] port_address_lines;
    logic [DATA_W-1:0] data_o;
    logic data_oe;
  } qpsram_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b011,
    ST_RECOVER = 3'b100
  } qpsram_state_t;

endpackage

// file: logic/qpsram_arb.sv
`timescale 1ns/100ps
// same-location write guard: lowest port wins, others see inhibit
module qpsram_arb
(
  input wire logic [qpsram_pkg::NPORTS-1:0] wr_active,
  input wire logic [qpsram_pkg::NPORTS*qpsram_pkg::ADDR_W-1:0] wr_addr,
  output logic [qpsram_pkg::NPORTS-1:0] blocked
);

  genvar gi;
  generate
    for (gi = 0; gi < qpsram_pkg::NPORTS; gi++)
    begin : g_port
      logic [qpsram_pkg::NPORTS-1:0] hit;
      genvar gj;
      for (gj = 0; gj < qpsram_pkg::NPORTS; gj++)
      begin : g_other
        if (gj < gi)
        begin : g_lower
          assign hit[gj] = wr_active[gj] &&
            wr_addr[gj*qpsram_pkg::ADDR_W +: qpsram_pkg::ADDR_W] ==
            wr_addr[gi*qpsram_pkg::ADDR_W +: qpsram_pkg::ADDR_W];
        end
        else
        begin : g_none
          assign hit[gj] = 1'b0;
        end
      end
      assign blocked[gi] = |hit; // see RULE_15
    end
  endgenerate

endmodule

// file: logic/qpsram_host.sv
`timescale 1ns/100ps
// Notes on behaviour
// RULE_01: ce high deselects port, data floats
// RULE_02: all four ce high gives power-down
// RULE_03: ce low, rw low writes unless inhibited
// RULE_04: ce, oe low with rw high reads
// RULE_05: outputs drive only with oe low reading
// RULE_06: any selected port reaches every location
// RULE_07: write is the overlap of ce, rw low
// RULE_08: address changes only while rw/ce high
// RULE_09: ce after rw keeps outputs floating
// RULE_10: no drive while device outputs active
// RULE_11: oe low write pulse stretched to wz+dw
// RULE_12: address and data valid 15 ns before end
// RULE_13: inhibit low blocks write, zero lead
// RULE_14: hold write 15 ns after inhibit release
// RULE_15: never two same-address writes at once
// RULE_16: cross-port data visible within 35 ns
// RULE_17: read data valid 20 ns after address
// RULE_18: eleven address bits, eight data lines
// RULE_19: concurrent read may see old or new
module qpsram_host
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [qpsram_pkg::NPORTS-1:0] req_valid,
  input wire qpsram_pkg::qpsram_req_t [qpsram_pkg::NPORTS-1:0] req,
  output logic [qpsram_pkg::NPORTS-1:0] req_ready,
  output logic [qpsram_pkg::NPORTS-1:0] done_pulse,
  output logic [qpsram_pkg::NPORTS*qpsram_pkg::DATA_W-1:0] rdata,
  output logic all_standby,
  output qpsram_pkg::qpsram_pins_t [qpsram_pkg::NPORTS-1:0] pins,
  input wire logic [qpsram_pkg::NPORTS*qpsram_pkg::DATA_W-1:0] data_i
);

  localparam int unsigned NP = qpsram_pkg::NPORTS;
  localparam int unsigned AW = qpsram_pkg::ADDR_W;
  localparam int unsigned DW = qpsram_pkg::DATA_W;

  logic [NP-1:0] wr_active;
  logic [NP-1:0] blocked;
  logic [NP*AW-1:0] wr_addr;
  logic [NP-1:0] ce_n_vec;

  //////////////////////////////////////////////////////////////////////
  // per-port sequencer
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_port
      qpsram_pkg::qpsram_state_t state_r;
      qpsram_pkg::qpsram_req_t cur_r;
      logic [3:0] cnt_r;
      logic [3:0] wh_r;
      logic inh_r;
      logic ce_n_r;
      logic rw_r;
      logic oe_n_r;
      logic data_oe_r;
      logic ready_r;
      logic done_r;
      logic [DW-1:0] rdata_r;

      assign wr_active[gp] = (state_r == qpsram_pkg::ST_SETUP ||
        state_r == qpsram_pkg::ST_WRITE) && cur_r.we;
      assign wr_addr[gp*AW +: AW] = cur_r.addr;
      assign ce_n_vec[gp] = ce_n_r;

      // control and sequencing
      always_ff @(posedge sys_clk)
      begin
        if (!nrst)
        begin
          state_r <= qpsram_pkg::ST_IDLE;
          cur_r <= '0;
          cnt_r <= qpsram_pkg::CNT_ZERO;
          wh_r <= qpsram_pkg::CNT_ZERO;
          inh_r <= 1'b0;
          ce_n_r <= 1'b1; // see RULE_01
          rw_r <= 1'b1;
          oe_n_r <= 1'b1;
          data_oe_r <= 1'b0;
          ready_r <= 1'b0;
          done_r <= 1'b0;
          rdata_r <= '0;
        end
        else if (clk_en)
        begin
          done_r <= 1'b0;
          unique case (state_r)
            qpsram_pkg::ST_IDLE:
            begin
              // one idle cycle before ready spaces back-to-back work
              ready_r <= 1'b1;
              if (req_valid[gp] && ready_r)
              begin
                // address set while rw and ce high
                cur_r <= req[gp]; // see RULE_08
                ready_r <= 1'b0;
                state_r <= qpsram_pkg::ST_SETUP;
              end
            end
            qpsram_pkg::ST_SETUP:
            begin
              ce_n_r <= 1'b0; // see RULE_06
              if (cur_r.we)
              begin
                // rw falls with ce so outputs stay floating
                rw_r <= 1'b0; // see RULE_09
                oe_n_r <= ~cur_r.oe_during_write;
                data_oe_r <= ~cur_r.oe_during_write; // see RULE_10
                inh_r <= blocked[gp]; // see RULE_13
                cnt_r <= cur_r.oe_during_write ? qpsram_pkg::WPOE_CYC
                                               : qpsram_pkg::WP_CYC;
                wh_r <= qpsram_pkg::WH_CYC;
                state_r <= qpsram_pkg::ST_WRITE;
              end
              else
              begin
                // rw stays high on a read, so data_oe stays low
                oe_n_r <= 1'b0; // see RULE_04
                cnt_r <= qpsram_pkg::RD_CYC; // see RULE_17
                state_r <= qpsram_pkg::ST_READ;
              end
            end
            qpsram_pkg::ST_WRITE:
            begin
              // oe-low write: drive data only once device floats
              if (!data_oe_r && cnt_r == qpsram_pkg::XP_CYC)
                data_oe_r <= 1'b1; // see RULE_11
              // a lower port may claim the location mid-write, so
              // the guard is watched every cycle, not only at start
              inh_r <= blocked[gp]; // see RULE_13
              if (inh_r || blocked[gp])
              begin
                // stall until contention clears, then full hold
                wh_r <= qpsram_pkg::WH_CYC; // see RULE_14
              end
              else if (wh_r != qpsram_pkg::CNT_ZERO)
                wh_r <= wh_r - qpsram_pkg::CNT_ONE;
              if (cnt_r != qpsram_pkg::CNT_ZERO)
                cnt_r <= cnt_r - qpsram_pkg::CNT_ONE; // see RULE_12
              else if (!inh_r && !blocked[gp] &&
                wh_r == qpsram_pkg::CNT_ZERO)
              begin
                // ending both together closes the overlap
                rw_r <= 1'b1; // see RULE_07
                ce_n_r <= 1'b1;
                oe_n_r <= 1'b1;
                cnt_r <= qpsram_pkg::XP_CYC; // see RULE_16
                state_r <= qpsram_pkg::ST_RECOVER;
              end
            end
            qpsram_pkg::ST_READ:
            begin
              if (cnt_r != qpsram_pkg::CNT_ZERO)
                cnt_r <= cnt_r - qpsram_pkg::CNT_ONE;
              else
              begin
                // one extra cycle past access covers port-to-port lag
                rdata_r <= data_i[gp*DW +: DW]; // see RULE_19
                ce_n_r <= 1'b1;
                oe_n_r <= 1'b1; // see RULE_05
                cnt_r <= qpsram_pkg::HZ_CYC;
                state_r <= qpsram_pkg::ST_RECOVER;
              end
            end
            qpsram_pkg::ST_RECOVER:
            begin
              data_oe_r <= 1'b0;
              if (cnt_r != qpsram_pkg::CNT_ZERO)
                cnt_r <= cnt_r - qpsram_pkg::CNT_ONE;
              else
              begin
                done_r <= 1'b1;
                state_r <= qpsram_pkg::ST_IDLE;
              end
            end
            default:
              state_r <= qpsram_pkg::ST_IDLE;
          endcase
        end
      end

      //////////////////////////////////////////////////////////////////////
      // status and pin outputs, all straight from flops
      assign req_ready[gp] = ready_r;
      assign done_pulse[gp] = done_r;
      assign rdata[gp*DW +: DW] = rdata_r;
      assign pins[gp].ce_n = ce_n_r;
      assign pins[gp].rw = rw_r;
      assign pins[gp].oe_n = oe_n_r;
      assign pins[gp].inhibit_n = ~inh_r; // see RULE_03
      assign pins[gp].port_address_lines = cur_r.addr; // see RULE_18
      assign pins[gp].data_o = cur_r.wdata;
      assign pins[gp].data_oe = data_oe_r;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // contention guard
  qpsram_arb u_arb
  (
    .wr_active(wr_active),
    .wr_addr(wr_addr),
    .blocked(blocked)
  );

  //////////////////////////////////////////////////////////////////////
  // whole-device standby flag, registered
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      all_standby <= 1'b1;
    else if (clk_en)
      // status only: the device powers down from its own select pins
      all_standby <= &ce_n_vec; // see RULE_02
  end

endmodule

// file: tb/qpsram_chk.sv
`timescale 1ns/100ps
module qpsram_chk
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [qpsram_pkg::NPORTS-1:0] req_valid,
  input wire logic [qpsram_pkg::NPORTS-1:0] req_ready,
  input wire logic [qpsram_pkg::NPORTS-1:0] done_pulse,
  input wire logic all_standby,
  input wire qpsram_pkg::qpsram_pins_t [qpsram_pkg::NPORTS-1:0] pins
);
  logic [qpsram_pkg::NPORTS-1:0] ce_v;
  logic [qpsram_pkg::NPORTS-1:0] wr_v;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  a_standby_flag: assert property (all_standby == $past(&ce_v))
    else $error("standby flag wrong");
  //////////////////////////////////////////////////////////////////////////
  for (genvar p = 0; p < qpsram_pkg::NPORTS; p++)
  begin : g_port
    assign ce_v[p] = pins[p].ce_n;
    assign wr_v[p] = !pins[p].ce_n && !pins[p].rw && pins[p].inhibit_n;
    a_read_no_drive: assert property (
      !pins[p].ce_n && pins[p].rw && !pins[p].oe_n |-> !pins[p].data_oe)
      else $error("host drives while device outputs");
    a_rw_with_ce: assert property (
      $fell(pins[p].rw) |-> $fell(pins[p].ce_n))
      else $error("rw fell apart from select");
    a_addr_hold: assert property (
      (!pins[p].ce_n && !pins[p].rw) ##1 (!pins[p].ce_n && !pins[p].rw)
      |-> $stable(pins[p].port_address_lines))
      else $error("address moved in write");
    a_end_valid: assert property (
      $rose(pins[p].rw) |->
      $past(pins[p].data_oe) && $past(pins[p].inhibit_n))
      else $error("data or release late at write end");
    a_pulse_width: assert property ($fell(pins[p].rw) |=> !pins[p].rw)
      else $error("write pulse too short");
    a_done_single: assert property (done_pulse[p] |=> !done_pulse[p])
      else $error("done longer than one cycle");
    a_take_busy: assert property (req_valid[p] && req_ready[p] |=>
      !req_ready[p]) else $error("ready stayed after take");
    a_ready_back: assert property (done_pulse[p] |-> ##[1:2] req_ready[p])
      else $error("ready not back after done");
    a_no_clash: assert property (
      (p == 0) || !(wr_v[p] && wr_v[0] &&
      pins[p].port_address_lines == pins[0].port_address_lines))
      else $error("two writes to one location");
  end
  c_write_end: cover property ($rose(pins[0].rw));
  c_inhibit: cover property (!pins[1].inhibit_n && !pins[1].rw);
  c_read: cover property (!pins[2].ce_n && !pins[2].oe_n && pins[2].rw);
endmodule
bind qpsram_host qpsram_chk u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .req_valid(req_valid), .req_ready(req_ready), .done_pulse(done_pulse),
  .all_standby(all_standby), .pins(pins));

// file: tb/qpsram_mem_model.sv
`timescale 1ns/100ps
module qpsram_mem_model
(
  input wire logic sys_clk,
  input wire qpsram_pkg::qpsram_pins_t [qpsram_pkg::NPORTS-1:0] pins,
  output logic [qpsram_pkg::NPORTS*qpsram_pkg::DATA_W-1:0] data_i,
  output logic pwr_down
);
  logic [7:0] mem_r [0:(1 << qpsram_pkg::ADDR_W)-1];
  logic [31:0] last_r = 32'h0000_0000;
  assign pwr_down = &{pins[3].ce_n, pins[2].ce_n, pins[1].ce_n,
    pins[0].ce_n};
  always @(posedge sys_clk)
  begin
    for (int p = 0; p < 4; p++)
    begin
      // undriven lines store garbage, so late data shows up
      if (!pins[p].ce_n && !pins[p].rw &&
        pins[p].inhibit_n)
        mem_r[pins[p].port_address_lines] <= pins[p].data_oe ?
          pins[p].data_o : ~pins[p].data_o;
      last_r[p*8 +: 8] <= data_i[p*8 +: 8];
    end
  end
  // floating lines flip every cycle, never hold the last byte
  always_comb
    for (int p = 0; p < 4; p++)
      data_i[p*8 +: 8] =
        (!pins[p].ce_n && pins[p].rw && !pins[p].oe_n) ?
        mem_r[pins[p].port_address_lines] :
        ~last_r[p*8 +: 8];
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic sys_clk;
  logic nrst;
  logic clk_en;
  logic [3:0] req_valid;
  qpsram_pkg::qpsram_req_t [3:0] req;
  logic [3:0] req_ready;
  logic [3:0] done_pulse;
  logic [31:0] rdata;
  logic all_standby;
  logic pwr_down;
  qpsram_pkg::qpsram_pins_t [3:0] pins;
  logic [31:0] data_i;
  logic inh_seen;
  int err_total;
  int n_checks;
  qpsram_host u_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .done_pulse(done_pulse), .rdata(rdata), .all_standby(all_standby),
    .pins(pins), .data_i(data_i));
  qpsram_mem_model u_mem (.sys_clk(sys_clk), .pins(pins), .data_i(data_i),
    .pwr_down(pwr_down));
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    if (!pins[1].inhibit_n && !pins[1].ce_n)
      inh_seen <= 1'b1;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask
  task automatic xfer(input int p, input logic we, input logic oe,
    input logic [10:0] a, input logic [7:0] d);
    int n;
    @(negedge sys_clk);
    req[p] = '{we, oe, a, d};
    req_valid[p] = 1'b1;
    n = 0;
    while (req_ready[p] !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    req_valid[p] = 1'b0;
    while (done_pulse[p] !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk1(n < 100, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    chk1(all_standby, 1'b1);
    for (int p = 0; p < 4; p++)
    begin
      chk1(pins[p].ce_n, 1'b1);
      chk1(pins[p].data_oe, 1'b0);
    end
    chk1(pwr_down, 1'b1);
  endtask
  // boundary and mid-range addresses, each byte read back through the next port
  task automatic s_ports();
    logic [10:0] a;
    int q;
    for (int p = 0; p < 4; p++)
    begin
      a = (p == 0) ? 11'h000 : (p == 1) ? 11'h7ff : 11'h555 - p;
      q = (p + 1) % 4;
      xfer(p, 1'b1, 1'b0, a, 8'ha5 ^ p[7:0]);
      xfer(q, 1'b0, 1'b0, a, 8'h00);
      chk8(rdata[q*8 +: 8], 8'ha5 ^ p[7:0]);
    end
  endtask
  task automatic s_oe_write();
    xfer(2, 1'b1, 1'b1, 11'h123, 8'h3c);
    xfer(2, 1'b0, 1'b0, 11'h123, 8'h00);
    chk8(rdata[23:16], 8'h3c);
  endtask
  // both writers start together; the loser completes after release
  task automatic s_clash();
    inh_seen = 1'b0;
    fork
      xfer(0, 1'b1, 1'b0, 11'h0f0, 8'h11);
      xfer(1, 1'b1, 1'b0, 11'h0f0, 8'h22);
    join
    chk1(inh_seen, 1'b1);
    xfer(3, 1'b0, 1'b0, 11'h0f0, 8'h00);
    chk8(rdata[31:24], 8'h22);
    // port 1 already writing when port 0 starts: port 1 steps aside
    inh_seen = 1'b0;
    fork
      xfer(1, 1'b1, 1'b0, 11'h0f1, 8'h44);
      begin
        @(negedge sys_clk);
        xfer(0, 1'b1, 1'b0, 11'h0f1, 8'h33);
      end
    join
    chk1(inh_seen, 1'b1);
    xfer(2, 1'b0, 1'b0, 11'h0f1, 8'h00);
    chk8(rdata[23:16], 8'h44);
  endtask
  // clock enable low mid-write must hold rw low for four cycles
  task automatic s_freeze();
    fork
      xfer(3, 1'b1, 1'b0, 11'h2aa, 8'h5a);
      begin
        while (pins[3].rw !== 1'b0)
          @(negedge sys_clk);
        @(negedge sys_clk);
        clk_en = 1'b0;
        repeat (4)
        begin
          @(negedge sys_clk);
          chk1(pins[3].rw, 1'b0);
        end
        chk1(all_standby, 1'b0);
        chk1(pwr_down, 1'b0);
        clk_en = 1'b1;
      end
    join
    xfer(0, 1'b0, 1'b0, 11'h2aa, 8'h00);
    chk8(rdata[7:0], 8'h5a);
  endtask
  task automatic end_of_test();
    $display("checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    $display("unexpected at %0t: watchdog ran out", $time);
    end_of_test();
  end
  initial
  begin
    nrst = 1'b0;
    clk_en = 1'b1;
    req_valid = 4'h0;
    req = '0;
    inh_seen = 1'b0;
    err_total = 0;
    n_checks = 0;
    repeat (5) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    s_reset();
    s_ports();
    s_oe_write();
    s_clash();
    s_freeze();
    repeat (3) @(negedge sys_clk);
    chk1(all_standby, 1'b1);
    chk1(pwr_down, 1'b1);
    end_of_test();
  end
endmodule
